// [bench/nlc_far_model.sv]
// Far side of the shared pins: indicator lamps, or an external phy.
// Assumes the pins are plain registered outputs of the block.
`timescale 1ns/100ps
module nlc_far_model (
   // Clock
   input wire logic aclk,
   // Pins from the block
   input wire logic link_indicator,
   input wire logic tx_activity_indicator_n,
   input wire logic rx_activity_indicator_n,
   input wire logic collision_indicator_n,
   input wire logic duplex_indicator_n,
   input wire logic speed_indicator_n,
   // Lamp view: link, tx, rx, collision, full duplex, 100M
   output logic [5:0] lamp_lit,
   // Phy view: nibble captured on each rising edge
   output logic phy_tx_en,
   output logic [3:0] phy_txd
);
   // Lamps glow when the pin is at its active level
   assign lamp_lit = {link_indicator, ~tx_activity_indicator_n, ~rx_activity_indicator_n,
                      ~collision_indicator_n, ~duplex_indicator_n, ~speed_indicator_n};

   // Phy samples enable and nibble, bit 3 first in weight
   always_ff @(posedge aclk) begin
      phy_tx_en <= tx_activity_indicator_n;
      phy_txd <= {rx_activity_indicator_n, collision_indicator_n, duplex_indicator_n,
                  speed_indicator_n};
   end
endmodule : nlc_far_model

// [bench/tb.sv]
// Self-checking bench for the indicator, shared-pin and clock select block.
// Assumes the package, design files and far model are compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb
   import nlc_pkg::*;
   ;
   // Clock, reset, strap
   logic aclk = 0;
   logic aresetn = 0;
   logic [3:0] cfg_select = 4'h0;
   // Line and mac inputs
   logic link_up = 0, line_tx_active = 0, line_rx_active = 0, line_collision = 0;
   logic an_full_duplex = 0, an_speed100 = 0, mii_tx_en_src = 0;
   logic [3:0] mii_txd_src = 4'h0;
   // Block outputs
   logic link_indicator, tx_activity_indicator_n, rx_activity_indicator_n;
   logic collision_indicator_n, duplex_indicator_n, speed_indicator_n;
   logic ref_use_crystal, ref_use_oscillator, pll_enable;
   logic [7:0] pll_mult;
   // Register bus
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   // Far side view
   logic [5:0] lamp_lit;
   logic phy_tx_en;
   logic [3:0] phy_txd;
   // Bench state
   int fail_count = 0;
   int n_compared = 0;
   logic [31:0] rd;
   logic [1:0] rsp;

   // 200 MHz clock
   always #2.5 aclk = ~aclk;

   // Short stretch keeps lamp waits within about 400 cycles
   nlc_top #(.STRETCH_W(6), .STRETCH_TICKS(6'h02)) dut_u (
      .aclk(aclk), .aresetn(aresetn), .cfg_select(cfg_select), .link_up(link_up),
      .line_tx_active(line_tx_active), .line_rx_active(line_rx_active),
      .line_collision(line_collision), .an_full_duplex(an_full_duplex),
      .an_speed100(an_speed100), .mii_tx_en_src(mii_tx_en_src), .mii_txd_src(mii_txd_src),
      .link_indicator(link_indicator), .tx_activity_indicator_n(tx_activity_indicator_n),
      .rx_activity_indicator_n(rx_activity_indicator_n),
      .collision_indicator_n(collision_indicator_n), .duplex_indicator_n(duplex_indicator_n),
      .speed_indicator_n(speed_indicator_n), .ref_use_crystal(ref_use_crystal),
      .ref_use_oscillator(ref_use_oscillator), .pll_enable(pll_enable), .pll_mult(pll_mult),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));

   // Lamps and phy on the far side
   nlc_far_model far_u (
      .aclk(aclk), .link_indicator(link_indicator),
      .tx_activity_indicator_n(tx_activity_indicator_n),
      .rx_activity_indicator_n(rx_activity_indicator_n),
      .collision_indicator_n(collision_indicator_n), .duplex_indicator_n(duplex_indicator_n),
      .speed_indicator_n(speed_indicator_n), .lamp_lit(lamp_lit), .phy_tx_en(phy_tx_en),
      .phy_txd(phy_txd));

   // Verdict and end of run
   task automatic finish_test;
      if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test

   // Pass n edges, then let their updates land
   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask : settle

   // Strap is held through the five reset cycles
   task automatic do_reset(input logic [3:0] c);
      @(posedge aclk);
      aresetn <= 1'b0;
      cfg_select <= c;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      settle(1);
   endtask : do_reset

   // Write one word; each channel held until its own ready
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw_ok;
      bit w_ok;
      aw_ok = 0;
      w_ok = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   // Read one word; data taken at the rvalid edge
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   // Hang guard, well above the expected run
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end

   // Main sequence
   initial begin
      // Internal phy mode: crystal, pll up, lamps idle
      do_reset(NLC_CFG_INT_PHY);
      `CHK({ref_use_crystal, ref_use_oscillator}, 2'b10)
      `CHK({pll_enable, pll_mult}, 9'h106)
      `CHK(lamp_lit, 6'h00)
      axi_rd(NLC_REG_PLL, rd, rsp);
      `CHK(rd[8:0], 9'h106)
      axi_rd(NLC_REG_STATUS, rd, rsp);
      `CHK(rd[11:6], 6'h01)
      // Link lamp follows the media link
      @(posedge aclk);
      link_up <= 1'b1;
      settle(2);
      `CHK(lamp_lit[5], 1'b1)
      @(posedge aclk);
      link_up <= 1'b0;
      settle(2);
      `CHK(link_indicator, 1'b0)
      // Transmit, then receive activity; lamp lit, then stretched out
      for (int i = 0; i < 2; i++) begin
         @(posedge aclk);
         if (i == 0) line_tx_active <= 1'b1;
         else line_rx_active <= 1'b1;
         settle(3);
         `CHK(lamp_lit[4 - i], 1'b1)
         `CHK(lamp_lit[3 + i], 1'b0)
         line_tx_active <= 1'b0;
         line_rx_active <= 1'b0;
         settle(900);
         `CHK(lamp_lit[4 - i], 1'b0)
      end
      // Collision shows in half duplex only
      @(posedge aclk);
      line_collision <= 1'b1;
      settle(3);
      `CHK(collision_indicator_n, 1'b0)
      line_collision <= 1'b0;
      an_full_duplex <= 1'b1;
      an_speed100 <= 1'b1;
      settle(900);
      `CHK({duplex_indicator_n, speed_indicator_n}, 2'b00)
      line_collision <= 1'b1;
      settle(3);
      `CHK(collision_indicator_n, 1'b1)
      settle(20);
      `CHK(collision_indicator_n, 1'b1)
      line_collision <= 1'b0;
      an_full_duplex <= 1'b0;
      an_speed100 <= 1'b0;
      settle(3);
      `CHK({duplex_indicator_n, speed_indicator_n}, 2'b11)
      // Manual setting overrides negotiation: 100M full, then 10M half
      axi_wr(NLC_REG_CTRL, 32'h3, rsp);
      settle(4);
      `CHK({duplex_indicator_n, speed_indicator_n}, 2'b00)
      an_full_duplex <= 1'b1;
      an_speed100 <= 1'b1;
      axi_wr(NLC_REG_CTRL, 32'h0, rsp);
      settle(4);
      `CHK({duplex_indicator_n, speed_indicator_n}, 2'b11)
      // Manual full duplex at 10M: the two fields are told apart
      axi_wr(NLC_REG_CTRL, 32'h1, rsp);
      settle(4);
      `CHK({duplex_indicator_n, speed_indicator_n}, 2'b01)
      axi_rd(NLC_REG_CTRL, rd, rsp);
      `CHK(rd[2:0], 3'h1)
      axi_wr(NLC_REG_CTRL, 32'h7, rsp);
      settle(4);
      `CHK({duplex_indicator_n, speed_indicator_n}, 2'b00)
      // Negotiated speed drops alone: only the speed lamp goes dark
      an_speed100 <= 1'b0;
      settle(3);
      `CHK({duplex_indicator_n, speed_indicator_n}, 2'b01)
      // Unmapped place refused, read-only place untouched
      axi_wr(8'h40, 32'hffffffff, rsp);
      `CHK(rsp, NLC_RESP_SLVERR)
      axi_rd(8'h40, rd, rsp);
      `CHK({rsp, rd}, {NLC_RESP_SLVERR, 32'h0})
      axi_wr(NLC_REG_PLL, 32'h0, rsp);
      axi_rd(NLC_REG_PLL, rd, rsp);
      `CHK(rd[8:0], 9'h106)
      // External phy, crystal: shared pins carry the nibble, activity ignored
      do_reset(NLC_CFG_EXT_XTAL);
      `CHK({ref_use_crystal, ref_use_oscillator}, 2'b10)
      line_tx_active <= 1'b1;
      link_up <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         @(posedge aclk);
         mii_tx_en_src <= i[0];
         mii_txd_src <= 4'h5 << i;
         settle(1);
         `CHK({tx_activity_indicator_n, rx_activity_indicator_n, collision_indicator_n,
               duplex_indicator_n, speed_indicator_n}, {i[0], 4'(4'h5 << i)})
         settle(1);
         `CHK({phy_tx_en, phy_txd}, {i[0], 4'(4'h5 << i)})
      end
      `CHK(link_indicator, 1'b1)
      line_tx_active <= 1'b0;
      link_up <= 1'b0;
      // External phy, oscillator
      do_reset(NLC_CFG_EXT_OSC);
      `CHK({ref_use_crystal, ref_use_oscillator}, 2'b01)
      axi_rd(NLC_REG_STATUS, rd, rsp);
      `CHK(rd[11:6], 6'h0a)
      // Back to internal phy: crystal again
      do_reset(NLC_CFG_INT_PHY);
      `CHK({ref_use_crystal, ref_use_oscillator}, 2'b10)
      finish_test();
   end
endmodule : tb

// [rtl/nlc_evt_if.sv]
// Event, tick and stretched level between the top and a stretcher.
// Assumes both ends run on the one block clock.
`timescale 1ns/100ps
interface nlc_evt_if;
   logic evt;  // Raw activity level
   logic tick; // Slow time base enable
   logic hold; // Stretched activity level
   modport src (output evt, output tick, input hold);
   modport dst (input evt, input tick, output hold);
endinterface : nlc_evt_if

// [rtl/nlc_pkg.sv]
// Constants shared by the network indicator and clock select block.
// Assumes a single 200 MHz clock and an AXI4-Lite register port.
package nlc_pkg;
   // Register byte offsets
   localparam logic [7:0] NLC_REG_CTRL = 8'h00;
   localparam logic [7:0] NLC_REG_STATUS = 8'h04;
   localparam logic [7:0] NLC_REG_PLL = 8'h08;
   localparam int NLC_ADDR_W = 8;

   // Chip configuration select codes
   localparam logic [3:0] NLC_CFG_INT_PHY = 4'h0;
   localparam logic [3:0] NLC_CFG_EXT_XTAL = 4'h1;
   localparam logic [3:0] NLC_CFG_EXT_OSC = 4'h2;

   // Control register: phy operation select field
   localparam logic [2:0] NLC_OPSEL_RESET = 3'h7;
   localparam int NLC_OPSEL_AUTO = 2;
   localparam int NLC_OPSEL_SPD100 = 1;
   localparam int NLC_OPSEL_FULL = 0;

   // Status register bit positions
   localparam int NLC_ST_LINK = 0;
   localparam int NLC_ST_FULL = 1;
   localparam int NLC_ST_SPD100 = 2;
   localparam int NLC_ST_TXACT = 3;
   localparam int NLC_ST_RXACT = 4;
   localparam int NLC_ST_COL = 5;
   localparam int NLC_ST_XTAL = 6;
   localparam int NLC_ST_OSC = 7;
   localparam int NLC_ST_CFG_LO = 8;

   // PLL register layout
   localparam int NLC_PLL_EN_BIT = 8;

   // Clock figures
   localparam int NLC_CLK_PERIOD_NS = 5;
   localparam int NLC_REF_MHZ = 25;
   localparam int NLC_CORE_MHZ = 150;
   localparam logic [7:0] NLC_PLL_MULT = 8'(NLC_CORE_MHZ / NLC_REF_MHZ);

   // Activity stretch tick: 1000 ns per tick
   localparam int NLC_TICK_NS = 1000;
   localparam int NLC_TICK_CYCLES = NLC_TICK_NS / NLC_CLK_PERIOD_NS;
   localparam int NLC_TICK_W = 8;

   // AXI responses
   localparam logic [1:0] NLC_RESP_OKAY = 2'h0;
   localparam logic [1:0] NLC_RESP_SLVERR = 2'h2;

   // Read channel states, one-hot
   typedef enum logic [1:0] {
      NLC_RD_IDLE = 2'h1,
      NLC_RD_RESP = 2'h2
   } nlc_rd_state_t;
endpackage : nlc_pkg

// [rtl/nlc_stretch.sv]
// Stretches an activity level so short bursts stay visible on a lamp.
// Assumes tick is a one-cycle enable from the caller's divider.
`timescale 1ns/100ps
module nlc_stretch
   import nlc_pkg::*;
#(
   parameter int TICKS_W = 6,
   parameter logic [TICKS_W-1:0] TICKS = 6'h10
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Event link
   nlc_evt_if.dst ev
);
   logic [TICKS_W-1:0] remain; // Ticks left after the event drops

   // Reload while active, count down on ticks afterwards
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         remain <= '0;
      end else if (ev.evt) begin
         remain <= TICKS;
      end else if (ev.tick && remain != '0) begin
         remain <= remain - 1'b1;
      end
   end

   // Level is high during the event and the stretch after it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev.hold <= 1'b0;
      end else begin
         ev.hold <= ev.evt || (remain != '0);
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_stretch_start: assert property (ev.evt |=> ev.hold) // [RL3]
      else $error("stretch level missed a live event");
endmodule : nlc_stretch

// [rtl/nlc_top.sv]
// Network indicator drivers, shared-pin select and reference clock select.
// Assumes synchronous inputs, a strap held through reset, AXI4-Lite master.
//
// Summary of operation
// RL1: Indicators on shared pins only in mode 0000
// RL2: Dedicated link lamp follows media link state
// RL3: Low transmit lamp while line sends data
// RL4: Low receive lamp while line receives data
// RL5: Low collision lamp only in half duplex
// RL6: Duplex lamp low full, high half
// RL7: Speed lamp low 100M, high 10M
// RL8: PLL multiplies 25 MHz reference to 150
// RL9: Crystal reference in modes 0000 and 0001
// RL10: Oscillator reference only in mode 0010
`timescale 1ns/100ps
module nlc_top
   import nlc_pkg::*;
#(
   parameter int STRETCH_W = 6,
   parameter logic [STRETCH_W-1:0] STRETCH_TICKS = 6'h10
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Configuration strap, caught in reset
   input wire logic [3:0] cfg_select,
   // Line and negotiation state
   input wire logic link_up,
   input wire logic line_tx_active,
   input wire logic line_rx_active,
   input wire logic line_collision,
   input wire logic an_full_duplex,
   input wire logic an_speed100,
   // MAC transmit side for external phy
   input wire logic mii_tx_en_src,
   input wire logic [3:0] mii_txd_src,
   // Indicator and shared pins
   output logic link_indicator,
   output logic tx_activity_indicator_n,
   output logic rx_activity_indicator_n,
   output logic collision_indicator_n,
   output logic duplex_indicator_n,
   output logic speed_indicator_n,
   // Clock select
   output logic ref_use_crystal,
   output logic ref_use_oscillator,
   output logic pll_enable,
   output logic [7:0] pll_mult,
   // AXI4-Lite write
   input wire logic [NLC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [NLC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [3:0] cfg_q;          // Captured configuration
   logic int_phy;              // Internal phy mode active
   logic [2:0] phy_operation_select; // Duplex and speed source
   logic full_q;               // Resolved full duplex
   logic spd_q;                // Resolved 100M speed
   logic [7:0] tick_cnt;       // Divider for the stretch tick
   logic tick;                 // One-cycle tick enable
   // Write channel holding state
   logic aw_got, w_got;        // Address or data already taken
   logic [NLC_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_now, w_now, do_write; // Handshakes this cycle, write commit
   logic [NLC_ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   nlc_rd_state_t rd_state;    // Read channel state

   nlc_evt_if tx_if (), rx_if (), col_if (); // Transmit, receive, collision links

   // Strap is caught while reset is held, frozen afterwards
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= cfg_select;
      end
   end
   assign int_phy = (cfg_q == NLC_CFG_INT_PHY);

   // Tick divider for lamp stretching
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= 8'h00;
         tick <= 1'b0;
      end else if (tick_cnt == 8'(NLC_TICK_CYCLES - 1)) begin
         tick_cnt <= 8'h00;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 8'h01;
         tick <= 1'b0;
      end
   end

   // Duplex and speed: negotiated or manual, registered once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         full_q <= 1'b0;
         spd_q <= 1'b0;
      end else if (phy_operation_select[NLC_OPSEL_AUTO]) begin
         full_q <= an_full_duplex; // [RL6]
         spd_q <= an_speed100;     // [RL7]
      end else begin
         full_q <= phy_operation_select[NLC_OPSEL_FULL]; // [RL6]
         spd_q <= phy_operation_select[NLC_OPSEL_SPD100]; // [RL7]
      end
   end

   // Activity stretchers; collisions are dropped in full duplex
   assign tx_if.evt = line_tx_active;                 // [RL3]
   assign rx_if.evt = line_rx_active;                 // [RL4]
   assign col_if.evt = line_collision && !full_q;     // [RL5]
   assign tx_if.tick = tick;
   assign rx_if.tick = tick;
   assign col_if.tick = tick;

   nlc_stretch #(.TICKS_W(STRETCH_W), .TICKS(STRETCH_TICKS)) u_tx (
      .aclk(aclk), .aresetn(aresetn), .ev(tx_if.dst));
   nlc_stretch #(.TICKS_W(STRETCH_W), .TICKS(STRETCH_TICKS)) u_rx (
      .aclk(aclk), .aresetn(aresetn), .ev(rx_if.dst));
   nlc_stretch #(.TICKS_W(STRETCH_W), .TICKS(STRETCH_TICKS)) u_col (
      .aclk(aclk), .aresetn(aresetn), .ev(col_if.dst));

   // Link lamp is never shared
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_indicator <= 1'b0;
      end else begin
         link_indicator <= link_up; // [RL2]
      end
   end

   // Shared pins: lamps in internal phy mode, MII transmit otherwise
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_activity_indicator_n <= 1'b1;
         rx_activity_indicator_n <= 1'b1;
         collision_indicator_n <= 1'b1;
         duplex_indicator_n <= 1'b1;
         speed_indicator_n <= 1'b1;
      end else if (int_phy) begin // [RL1]
         tx_activity_indicator_n <= !tx_if.hold;   // [RL3]
         rx_activity_indicator_n <= !rx_if.hold;   // [RL4]
         collision_indicator_n <= !col_if.hold || full_q; // [RL5]
         duplex_indicator_n <= !full_q;            // [RL6]
         speed_indicator_n <= !spd_q;              // [RL7]
      end else begin
         // Pins carry the MAC's transmit nibble, MSB on the receive lamp
         tx_activity_indicator_n <= mii_tx_en_src;  // [RL1]
         rx_activity_indicator_n <= mii_txd_src[3];
         collision_indicator_n <= mii_txd_src[2];
         duplex_indicator_n <= mii_txd_src[1];
         speed_indicator_n <= mii_txd_src[0];
      end
   end

   // Reference select; unknown codes fall back to the crystal
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_use_crystal <= 1'b0;
         ref_use_oscillator <= 1'b0;
         pll_enable <= 1'b0;
         pll_mult <= 8'h00;
      end else begin
         ref_use_oscillator <= (cfg_q == NLC_CFG_EXT_OSC); // [RL10]
         ref_use_crystal <= (cfg_q != NLC_CFG_EXT_OSC);    // [RL9]
         pll_enable <= 1'b1;                               // [RL8]
         pll_mult <= NLC_PLL_MULT;                         // [RL8]
      end
   end

   // Write address and data may arrive in either order
   assign aw_now = s_axi_awvalid && s_axi_awready;
   assign w_now = s_axi_wvalid && s_axi_wready;
   assign do_write = (aw_got || aw_now) && (w_got || w_now) && !s_axi_bvalid;
   assign wr_addr = aw_got ? aw_addr : s_axi_awaddr;
   assign wr_data = w_got ? w_data : s_axi_wdata;
   assign wr_strb = w_got ? w_strb : s_axi_wstrb;

   // Write channel handshakes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         // Held words need no reset: the got flags guard every use
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= NLC_RESP_OKAY;
      end else if (do_write) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_addr == NLC_REG_CTRL || wr_addr == NLC_REG_STATUS ||
            wr_addr == NLC_REG_PLL) ? NLC_RESP_OKAY : NLC_RESP_SLVERR;
      end else if (s_axi_bvalid) begin
         // Hold off new requests until the response is taken
         if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end else begin
         if (aw_now) begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_got) begin
            s_axi_awready <= 1'b1;
         end
         if (w_now) begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (!w_got) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Control register; only the low byte lane holds bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phy_operation_select <= NLC_OPSEL_RESET;
      end else if (do_write && wr_addr == NLC_REG_CTRL && wr_strb[0]) begin
         phy_operation_select <= wr_data[2:0];
      end
   end

   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state <= NLC_RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= NLC_RESP_OKAY;
      end else begin
         case (rd_state)
            NLC_RD_IDLE: begin
               s_axi_arready <= 1'b1;
               if (s_axi_arvalid && s_axi_arready) begin
                  rd_state <= NLC_RD_RESP;
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rresp <= NLC_RESP_OKAY;
                  s_axi_rdata <= 32'h0;
                  case (s_axi_araddr)
                     NLC_REG_CTRL: s_axi_rdata[2:0] <= phy_operation_select;
                     NLC_REG_STATUS: begin
                        s_axi_rdata[NLC_ST_LINK] <= link_indicator;
                        s_axi_rdata[NLC_ST_FULL] <= full_q;
                        s_axi_rdata[NLC_ST_SPD100] <= spd_q;
                        s_axi_rdata[NLC_ST_TXACT] <= tx_if.hold;
                        s_axi_rdata[NLC_ST_RXACT] <= rx_if.hold;
                        s_axi_rdata[NLC_ST_COL] <= col_if.hold;
                        s_axi_rdata[NLC_ST_XTAL] <= ref_use_crystal;
                        s_axi_rdata[NLC_ST_OSC] <= ref_use_oscillator;
                        s_axi_rdata[NLC_ST_CFG_LO +: 4] <= cfg_q;
                     end
                     NLC_REG_PLL: begin
                        s_axi_rdata[7:0] <= pll_mult;
                        s_axi_rdata[NLC_PLL_EN_BIT] <= pll_enable;
                     end
                     default: s_axi_rresp <= NLC_RESP_SLVERR;
                  endcase
               end
            end
            NLC_RD_RESP: begin
               s_axi_arready <= 1'b0;
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rd_state <= NLC_RD_IDLE;
               end
            end
            default: rd_state <= NLC_RD_IDLE; // Stray code: back to idle
         endcase
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_link_lamp_follow: assert property ($rose(link_up) |=> link_indicator) // [RL2]
      else $error("link lamp did not follow link");
   chk_shared_pins_mii: assert property (!int_phy |=>
      {rx_activity_indicator_n, collision_indicator_n, duplex_indicator_n,
       speed_indicator_n} == $past(mii_txd_src)) // [RL1]
      else $error("shared pins not carrying transmit nibble");
   chk_tx_lamp_on: assert property ((int_phy && line_tx_active) |-> ##2
      !tx_activity_indicator_n) // [RL3]
      else $error("transmit lamp off during transmit");
   chk_rx_lamp_on: assert property ((int_phy && line_rx_active) |-> ##2
      !rx_activity_indicator_n) // [RL4]
      else $error("receive lamp off during receive");
   chk_col_full_dark: assert property ((int_phy && full_q) |=> collision_indicator_n) // [RL5]
      else $error("collision lamp lit in full duplex");
   chk_duplex_lamp_value: assert property (int_phy |=>
      duplex_indicator_n == !$past(full_q)) // [RL6]
      else $error("duplex lamp level wrong");
   chk_speed_lamp_value: assert property (int_phy |=>
      speed_indicator_n == !$past(spd_q)) // [RL7]
      else $error("speed lamp level wrong");
   chk_pll_ratio_out: assert property ($past(aresetn) |-> pll_enable &&
      pll_mult == NLC_PLL_MULT) // [RL8]
      else $error("pll ratio or enable wrong");
   chk_ref_crystal_sel: assert property ($past(aresetn) && (cfg_q == NLC_CFG_INT_PHY ||
      cfg_q == NLC_CFG_EXT_XTAL) |-> ref_use_crystal && !ref_use_oscillator) // [RL9]
      else $error("crystal not selected");
   chk_ref_osc_sel: assert property (ref_use_oscillator |-> cfg_q == NLC_CFG_EXT_OSC) // [RL10]
      else $error("oscillator selected in wrong mode");
   chk_read_answer: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
      else $error("read answer late");
   chk_write_answer: assert property (do_write |=> s_axi_bvalid)
      else $error("write answer late");

   cov_tx_lamp: cover property (int_phy && line_tx_active ##2 !tx_activity_indicator_n);
   cov_half_collision: cover property (int_phy && !full_q && line_collision);
   cov_ext_mode_write: cover property (!int_phy && do_write);
endmodule : nlc_top
